// ==== core/tsac_pkg.sv ====
/*
 * tsac_pkg: constants shared by the temperature monitor control logic.
 * assumes: 40 MHz system clock, one clock domain.
 */
package tsac_pkg;

	// clock and conversion rates
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned AUTO_RATE_HZ   = 4;
	localparam int unsigned REMOTE_RATE_HZ = 8;

	// register pointer values
	localparam logic [7:0] PTR_LOCAL_TEMP   = 8'h00;
	localparam logic [7:0] PTR_REMOTE_TEMP  = 8'h01;
	localparam logic [7:0] PTR_STATUS       = 8'h02;
	localparam logic [7:0] PTR_SETUP_RD     = 8'h03;
	localparam logic [7:0] PTR_LOCAL_LIM_RD = 8'h05;
	localparam logic [7:0] PTR_REMOTE_LIM_RD= 8'h07;
	localparam logic [7:0] PTR_SETUP_WR     = 8'h09;
	localparam logic [7:0] PTR_LOCAL_LIM_WR = 8'h0b;
	localparam logic [7:0] PTR_REMOTE_LIM_WR= 8'h0d;
	localparam logic [7:0] PTR_SINGLE_SHOT  = 8'h0f;
	localparam logic [7:0] PTR_REMOTE_EXT   = 8'h10;
	localparam logic [7:0] PTR_LOCAL_EXT    = 8'h11;
	localparam logic [7:0] PTR_MAKER_ID     = 8'hfe;

	// flag_summary bit positions
	localparam int unsigned ST_BUSY_BIT   = 7;
	localparam int unsigned ST_LOCAL_BIT  = 6;
	localparam int unsigned ST_REMOTE_BIT = 4;
	localparam int unsigned ST_OPEN_BIT   = 2;

	// operating_setup bit positions, reset and writable bits
	localparam int unsigned CFG_MASK_BIT    = 7;
	localparam int unsigned CFG_STANDBY_BIT = 6;
	localparam int unsigned CFG_REMOTE_BIT  = 5;
	localparam int unsigned CFG_QUEUE_BIT   = 4;
	localparam logic [7:0]  CFG_RESET       = 8'h10;
	localparam logic [7:0]  CFG_WR_MASK     = 8'hf0;

	// reset values and diode fault result
	localparam logic [7:0] PTR_RESET          = 8'h00;
	localparam logic [7:0] LOCAL_LIMIT_RESET  = 8'h46;
	localparam logic [7:0] REMOTE_LIMIT_RESET = 8'h78;
	localparam logic [7:0] DIODE_FAULT_TEMP   = 8'hff;

	// alert response address and last bit index of a byte
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	localparam logic [2:0] LAST_BIT        = 3'h7;

	typedef enum logic [3:0] {
		SMB_IDLE     = 4'h0,
		SMB_ADDR     = 4'h1,
		SMB_ADDR_END = 4'h2,
		SMB_ACK      = 4'h3,
		SMB_RX       = 4'h4,
		SMB_RX_END   = 4'h5,
		SMB_TX       = 4'h6,
		SMB_TX_END   = 4'h7,
		SMB_TX_ACK   = 4'h8,
		SMB_WAIT     = 4'h9
	} tsac_smb_e;

	typedef enum logic [1:0] {
		SCH_IDLE   = 2'h0,
		SCH_LOCAL  = 2'h1,
		SCH_REMOTE = 2'h2
	} tsac_sch_e;

endpackage : tsac_pkg

// ==== core/tsac_conv_sched.sv ====
/*
 * tsac_conv_sched: conversion scheduler for local and remote channels.
 * assumes: converter answers each conv_req with one conv_done pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module tsac_conv_sched #(
	parameter int unsigned AUTO_PERIOD_CYC   = 10_000_000,
	parameter int unsigned REMOTE_PERIOD_CYC = 5_000_000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic standby,
	input  wire logic remote_only,
	input  wire logic single_shot,
	input  wire logic conv_done,
	output logic      conv_req,
	output logic      conv_sel,
	output logic      busy
);

	tsac_pkg::tsac_sch_e state_reg;
	logic [23:0]         timer_reg;
	logic                tick;
	logic                start;

	assign tick  = (timer_reg == 24'h000000);
	assign start = (state_reg == tsac_pkg::SCH_IDLE) &&
		((tick && !standby) || (single_shot && standby));
	assign busy  = (state_reg != tsac_pkg::SCH_IDLE);

	////////////////////////////////////////////////////////////////////////
	// rate timer, 8 hz when remote only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_reg <= 24'h000000;
		end else if (tick) begin
			timer_reg <= remote_only ? 24'(REMOTE_PERIOD_CYC - 1) :
				24'(AUTO_PERIOD_CYC - 1);
		end else begin
			timer_reg <= timer_reg - 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= tsac_pkg::SCH_IDLE;
			conv_req  <= 1'b0;
			conv_sel  <= 1'b0;
		end else begin
			conv_req <= 1'b0;
			unique case (state_reg)
				tsac_pkg::SCH_IDLE: begin
					if (start) begin
						conv_req  <= 1'b1;
						conv_sel  <= remote_only;
						state_reg <= remote_only ? tsac_pkg::SCH_REMOTE :
							tsac_pkg::SCH_LOCAL;
					end
				end
				tsac_pkg::SCH_LOCAL: begin
					if (conv_done) begin
						conv_req  <= 1'b1;
						conv_sel  <= 1'b1;
						state_reg <= tsac_pkg::SCH_REMOTE;
					end
				end
				tsac_pkg::SCH_REMOTE: begin
					if (conv_done) begin
						state_reg <= tsac_pkg::SCH_IDLE;
					end
				end
				default: begin
					state_reg <= tsac_pkg::SCH_IDLE;
				end
			endcase
		end
	end

endmodule : tsac_conv_sched

`default_nettype wire

// ==== core/tsac_top.sv ====
/*
 * tsac_top: smbus slave, registers, flags and alert of a two-channel
 * temperature monitor.
 * assumes: scl/sda/alert are open-drain pins resolved outside; converter
 * logic runs on clk and returns a 10-bit result per request.
 */
// Contract
// - status bit 7 shows conversion busy
// - status bit 6 latches local over-limit
// - status bit 4 latches remote over-limit
// - status bit 2 flags diode open
// - alert response uses bus arbitration
// - arbitration loser nacks, keeps alert low
// - alert response clears latch; refault reasserts
// - 8-bit pointer resets to zero
// - single shot in standby converts once
// - single shot ignored while single converting
// - single shot ignored in autonomous mode
// - setup bit 7 masks alert output
// - setup bit 6 selects standby
// - setup bit 5 remote only at 8hz
// - setup bit 4 needs two faults
// - one fixed 7-bit slave address
// - also answers alert response address
// - status read clears flags once cleared
// - flags read zero after reset
// - autonomous 4hz conversion after reset
// - alert released and cleared at reset
// - limits reset to 70 and 120
// - alert when temperature reaches limit
// - diode fault gives all ones, no alert
`timescale 1ns/1ps
`default_nettype none

module tsac_top #(
	parameter logic [6:0]  SLAVE_ADDR        = 7'h48,
	parameter logic [7:0]  MAKER_ID          = 8'h5a,  // arbitrary value
	parameter int unsigned AUTO_PERIOD_CYC   = tsac_pkg::CLK_HZ / tsac_pkg::AUTO_RATE_HZ,
	parameter int unsigned REMOTE_PERIOD_CYC = tsac_pkg::CLK_HZ / tsac_pkg::REMOTE_RATE_HZ
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            alert_out,
	output logic            alert_oe,
	output logic            conv_req,
	output logic            conv_sel,
	input  wire logic       conv_done,
	input  wire logic [9:0] conv_data,
	input  wire logic       diode_fault
);

	logic                rst_sync_reg;
	logic                rst_n;
	logic [2:0]          scl_sync_reg;
	logic [2:0]          sda_sync_reg;
	logic                scl_f_reg;
	logic                sda_f_reg;
	logic                scl_q_reg;
	logic                sda_q_reg;
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;
	tsac_pkg::tsac_smb_e smb_reg;
	logic [2:0]          bit_cnt_reg;
	logic [7:0]          shift_reg;
	logic                to_tx_reg;
	logic                is_ara_reg;
	logic                data_byte_reg;
	logic                acked_reg;
	logic                rx_stb_reg;
	logic                rx_data_reg;
	logic [7:0]          rx_byte_reg;
	logic                tx_done_reg;
	logic [7:0]          tx_byte;
	logic [7:0]          rd_data;
	logic [7:0]          register_pointer_reg;
	logic [7:0]          operating_setup_reg;
	logic [7:0]          local_limit_reg;
	logic [7:0]          remote_limit_reg;
	logic [9:0]          local_temp_reg;
	logic [9:0]          remote_temp_reg;
	logic                local_over_limit_flag;
	logic                remote_over_limit_flag;
	logic                open_flag_reg;
	logic                local_hot_reg;
	logic                remote_hot_reg;
	logic                alert_latch_reg;
	logic                single_shot;
	logic                busy;
	logic                status_read;
	logic                ara_done;
	logic [7:0]          conv_byte;
	logic                conv_hot;
	logic                conv_alert;

	////////////////////////////////////////////////////////////////////////
	// reset release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_sync_reg <= 1'b1;
			rst_n        <= rst_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and filter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg    <= 1'b1;
			sda_f_reg    <= 1'b1;
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_f_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_f_reg <= sda_sync_reg[2];
			end
			scl_q_reg <= scl_f_reg;
			sda_q_reg <= sda_f_reg;
		end
	end

	assign scl_rise  = scl_f_reg && !scl_q_reg;
	assign scl_fall  = !scl_f_reg && scl_q_reg;
	assign bus_start = scl_f_reg && scl_q_reg && sda_q_reg && !sda_f_reg;
	assign bus_stop  = scl_f_reg && scl_q_reg && !sda_q_reg && sda_f_reg;
	assign tx_byte   = is_ara_reg ? {SLAVE_ADDR, 1'b0} : rd_data;

	////////////////////////////////////////////////////////////////////////
	// smbus slave bit engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			smb_reg       <= tsac_pkg::SMB_IDLE;
			bit_cnt_reg   <= 3'h0;
			shift_reg     <= 8'h00;
			to_tx_reg     <= 1'b0;
			is_ara_reg    <= 1'b0;
			data_byte_reg <= 1'b0;
			acked_reg     <= 1'b0;
			sda_oe        <= 1'b0;
			rx_stb_reg    <= 1'b0;
			rx_data_reg   <= 1'b0;
			rx_byte_reg   <= 8'h00;
			tx_done_reg   <= 1'b0;
		end else begin
			rx_stb_reg  <= 1'b0;
			tx_done_reg <= 1'b0;
			if (bus_start) begin
				smb_reg       <= tsac_pkg::SMB_ADDR;
				bit_cnt_reg   <= 3'h0;
				data_byte_reg <= 1'b0;
				sda_oe        <= 1'b0;
			end else if (bus_stop) begin
				smb_reg <= tsac_pkg::SMB_IDLE;
				sda_oe  <= 1'b0;
			end else begin
				unique case (smb_reg)
					tsac_pkg::SMB_IDLE, tsac_pkg::SMB_WAIT: begin
						sda_oe <= 1'b0;
					end
					tsac_pkg::SMB_ADDR, tsac_pkg::SMB_RX: begin
						if (scl_rise) begin
							shift_reg   <= {shift_reg[6:0], sda_f_reg};
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
							if (bit_cnt_reg == tsac_pkg::LAST_BIT) begin
								smb_reg <= (smb_reg == tsac_pkg::SMB_ADDR) ?
									tsac_pkg::SMB_ADDR_END : tsac_pkg::SMB_RX_END;
							end
						end
					end
					tsac_pkg::SMB_ADDR_END: begin
						if (scl_fall) begin
							if (shift_reg[7:1] == SLAVE_ADDR) begin
								sda_oe     <= 1'b1;
								to_tx_reg  <= shift_reg[0];
								is_ara_reg <= 1'b0;
								smb_reg    <= tsac_pkg::SMB_ACK;
							end else if (shift_reg[7:1] == tsac_pkg::ALERT_RESP_ADDR &&
								shift_reg[0] && alert_latch_reg) begin
								sda_oe     <= 1'b1;
								to_tx_reg  <= 1'b1;
								is_ara_reg <= 1'b1;
								smb_reg    <= tsac_pkg::SMB_ACK;
							end else begin
								smb_reg <= tsac_pkg::SMB_WAIT;
							end
						end
					end
					tsac_pkg::SMB_ACK: begin
						if (scl_fall) begin
							bit_cnt_reg <= 3'h0;
							if (to_tx_reg) begin
								shift_reg <= tx_byte;
								sda_oe    <= !tx_byte[7];
								smb_reg   <= tsac_pkg::SMB_TX;
							end else begin
								sda_oe  <= 1'b0;
								smb_reg <= tsac_pkg::SMB_RX;
							end
						end
					end
					tsac_pkg::SMB_RX_END: begin
						if (scl_fall) begin
							rx_stb_reg    <= 1'b1;
							rx_data_reg   <= data_byte_reg;
							rx_byte_reg   <= shift_reg;
							data_byte_reg <= 1'b1;
							sda_oe        <= 1'b1;
							smb_reg       <= tsac_pkg::SMB_ACK;
						end
					end
					tsac_pkg::SMB_TX: begin
						if (scl_rise) begin
							if (!sda_oe && !sda_f_reg) begin
								smb_reg <= tsac_pkg::SMB_WAIT;
							end else begin
								bit_cnt_reg <= bit_cnt_reg + 3'h1;
								if (bit_cnt_reg == tsac_pkg::LAST_BIT) begin
									smb_reg <= tsac_pkg::SMB_TX_END;
								end
							end
						end else if (scl_fall) begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_oe    <= !shift_reg[6];
						end
					end
					tsac_pkg::SMB_TX_END: begin
						if (scl_fall) begin
							sda_oe      <= 1'b0;
							tx_done_reg <= 1'b1;
							smb_reg     <= tsac_pkg::SMB_TX_ACK;
						end
					end
					tsac_pkg::SMB_TX_ACK: begin
						if (scl_rise) begin
							acked_reg <= !sda_f_reg;
						end else if (scl_fall) begin
							if (acked_reg && !is_ara_reg) begin
								bit_cnt_reg <= 3'h0;
								shift_reg   <= tx_byte;
								sda_oe      <= !tx_byte[7];
								smb_reg     <= tsac_pkg::SMB_TX;
							end else begin
								smb_reg <= tsac_pkg::SMB_WAIT;
							end
						end
					end
					default: begin
						smb_reg <= tsac_pkg::SMB_IDLE;
						sda_oe  <= 1'b0;
					end
				endcase
			end
		end
	end

	assign sda_out     = 1'b0;
	assign status_read = tx_done_reg && !is_ara_reg &&
		(register_pointer_reg == tsac_pkg::PTR_STATUS);
	assign ara_done    = tx_done_reg && is_ara_reg;
	assign single_shot = rx_stb_reg && !rx_data_reg &&
		(rx_byte_reg == tsac_pkg::PTR_SINGLE_SHOT);

	////////////////////////////////////////////////////////////////////////
	// pointer and writable registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			register_pointer_reg <= tsac_pkg::PTR_RESET;
			operating_setup_reg  <= tsac_pkg::CFG_RESET;
			local_limit_reg      <= tsac_pkg::LOCAL_LIMIT_RESET;
			remote_limit_reg     <= tsac_pkg::REMOTE_LIMIT_RESET;
		end else if (rx_stb_reg) begin
			if (!rx_data_reg) begin
				register_pointer_reg <= rx_byte_reg;
			end else begin
				unique case (register_pointer_reg)
					tsac_pkg::PTR_SETUP_WR: begin
						operating_setup_reg <= rx_byte_reg & tsac_pkg::CFG_WR_MASK;
					end
					tsac_pkg::PTR_LOCAL_LIM_WR: begin
						local_limit_reg <= rx_byte_reg;
					end
					tsac_pkg::PTR_REMOTE_LIM_WR: begin
						remote_limit_reg <= rx_byte_reg;
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data select
	always_comb begin
		unique case (register_pointer_reg)
			tsac_pkg::PTR_LOCAL_TEMP:    rd_data = local_temp_reg[9:2];
			tsac_pkg::PTR_REMOTE_TEMP:   rd_data = remote_temp_reg[9:2];
			tsac_pkg::PTR_STATUS: begin
				rd_data = 8'h00;
				rd_data[tsac_pkg::ST_BUSY_BIT]   = busy;
				rd_data[tsac_pkg::ST_LOCAL_BIT]  = local_over_limit_flag;
				rd_data[tsac_pkg::ST_REMOTE_BIT] = remote_over_limit_flag;
				rd_data[tsac_pkg::ST_OPEN_BIT]   = open_flag_reg;
			end
			tsac_pkg::PTR_SETUP_RD:      rd_data = operating_setup_reg;
			tsac_pkg::PTR_LOCAL_LIM_RD:  rd_data = local_limit_reg;
			tsac_pkg::PTR_REMOTE_LIM_RD: rd_data = remote_limit_reg;
			tsac_pkg::PTR_REMOTE_EXT:    rd_data = {remote_temp_reg[1:0], 6'h00};
			tsac_pkg::PTR_LOCAL_EXT:     rd_data = {local_temp_reg[1:0], 6'h00};
			tsac_pkg::PTR_MAKER_ID:      rd_data = MAKER_ID;
			default:                     rd_data = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// conversion scheduler
	tsac_conv_sched #(
		.AUTO_PERIOD_CYC   (AUTO_PERIOD_CYC),
		.REMOTE_PERIOD_CYC (REMOTE_PERIOD_CYC)
	) u_sched (
		.clk         (clk),
		.rst_n       (rst_n),
		.standby     (operating_setup_reg[tsac_pkg::CFG_STANDBY_BIT]),
		.remote_only (operating_setup_reg[tsac_pkg::CFG_REMOTE_BIT]),
		.single_shot (single_shot),
		.conv_done   (conv_done),
		.conv_req    (conv_req),
		.conv_sel    (conv_sel),
		.busy        (busy)
	);

	assign conv_byte  = conv_data[9:2];
	assign conv_hot   = conv_sel ?
		(!diode_fault && conv_byte >= remote_limit_reg) :
		(conv_byte >= local_limit_reg);
	assign conv_alert = conv_done && conv_hot &&
		(!operating_setup_reg[tsac_pkg::CFG_QUEUE_BIT] ||
		(conv_sel ? remote_hot_reg : local_hot_reg));

	////////////////////////////////////////////////////////////////////////
	// results and current fault conditions
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			local_temp_reg  <= 10'h000;
			remote_temp_reg <= 10'h000;
			local_hot_reg   <= 1'b0;
			remote_hot_reg  <= 1'b0;
		end else if (conv_done) begin
			if (conv_sel) begin
				remote_temp_reg <= diode_fault ?
					{tsac_pkg::DIODE_FAULT_TEMP, 2'h0} : conv_data;
				remote_hot_reg  <= conv_hot;
			end else begin
				local_temp_reg <= conv_data;
				local_hot_reg  <= conv_hot;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags, set wins over clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			local_over_limit_flag  <= 1'b0;
			remote_over_limit_flag <= 1'b0;
			open_flag_reg          <= 1'b0;
		end else begin
			if (conv_done && !conv_sel && conv_hot) begin
				local_over_limit_flag <= 1'b1;
			end else if (status_read && !local_hot_reg) begin
				local_over_limit_flag <= 1'b0;
			end
			if (conv_done && conv_sel && conv_hot) begin
				remote_over_limit_flag <= 1'b1;
			end else if (status_read && !remote_hot_reg) begin
				remote_over_limit_flag <= 1'b0;
			end
			if (conv_done && conv_sel && diode_fault) begin
				open_flag_reg <= 1'b1;
			end else if (status_read && !diode_fault) begin
				open_flag_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// alert latch and open-drain output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_latch_reg <= 1'b0;
		end else if (conv_alert) begin
			alert_latch_reg <= 1'b1;
		end else if (ara_done ||
			(status_read && !local_hot_reg && !remote_hot_reg)) begin
			alert_latch_reg <= 1'b0;
		end
	end

	assign alert_out = 1'b0;
	assign alert_oe  = alert_latch_reg &&
		!operating_setup_reg[tsac_pkg::CFG_MASK_BIT];

endmodule : tsac_top

`default_nettype wire

// ==== tb/tsac_top_sva.sv ====
/* tsac_top_sva: port assertions for tsac_top.
 * assumes: bound to tsac_top, single clk domain. */
`timescale 1ns/1ps
`default_nettype none
module tsac_top_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alert_out,
	input wire logic alert_oe,
	input wire logic conv_req,
	input wire logic conv_sel,
	input wire logic conv_done,
	input wire logic diode_fault
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sda_low_value_a: assert property (sda_out == 1'b0) else $error("sda drive value");
	alert_low_value_a: assert property (alert_out == 1'b0) else $error("alert drive value");
	sda_pull_timing_a: assert property ($rose(sda_oe) |-> !scl_in) else $error("sda pulled, scl high");
	req_pulse_a: assert property (conv_req |=> !conv_req) else $error("conv_req not a pulse");
	sel_hold_a: assert property (!conv_req |-> $stable(conv_sel)) else $error("conv_sel moved");
	first_conv_a: assert property ($rose(nrst) |-> ##[1:6] (conv_req && !conv_sel))
		else $error("no local conversion after reset");
	alert_clear_a: assert property ($rose(nrst) |-> !alert_oe [*3]) else $error("alert after reset");
	diode_quiet_a: assert property (conv_done && conv_sel && diode_fault && !alert_oe |=> !alert_oe)
		else $error("diode fault raised alert");
endmodule : tsac_top_sva
////////////////////////////////////////
bind tsac_top tsac_top_sva u_sva (.clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .conv_req(conv_req),
	.conv_sel(conv_sel), .conv_done(conv_done), .diode_fault(diode_fault));
`default_nettype wire

// ==== tb/tsac_host_model.sv ====
/* tsac_host_model: smbus host master, bit-level tasks.
 * assumes: sda_line is the pulled-up wired level; scl idles high. */
`timescale 1ns/1ps
`default_nettype none
module tsac_host_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda
);
	localparam int H = 16;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask : hw
	////////////////////////////////////////
	task automatic start;
		sda = 1'b1;
		hw(H);
		scl = 1'b1;
		hw(H);
		sda = 1'b0;
		hw(H);
		scl = 1'b0;
		hw(8);
	endtask : start
	task automatic stop;
		sda = 1'b0;
		hw(H);
		scl = 1'b1;
		hw(H);
		sda = 1'b1;
		hw(H);
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		sda = b;
		hw(H);
		scl = 1'b1;
		hw(H);
		r = sda_line;
		scl = 1'b0;
		hw(8);
	endtask : bitx
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, ack);
	endtask : wbyte
	// comp bits stand in for a rival slave; all ones for a plain read
	task automatic rbyte(output logic [7:0] v, input logic [7:0] comp);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(comp[i], v[i]);
		bitx(1'b1, r);
	endtask : rbyte
endmodule : tsac_host_model
`default_nettype wire

// ==== tb/tsac_top_tb_top.sv ====
/* tsac_top_tb_top: self-checking bench for tsac_top.
 * assumes: host model on scl/sda, converter model on conv ports. */
`timescale 1ns/1ps
`default_nettype none
module tsac_top_tb_top;
	localparam int AP = 2000;
	localparam int RP = 1000;
	localparam logic [6:0] SA = 7'h48;
	logic clk = 1'b0, nrst = 1'b0, conv_done = 1'b0, diode_fault = 1'b0;
	logic sda_out, sda_oe, alert_out, alert_oe, conv_req, conv_sel, scl, hsda, ack;
	logic [7:0] t_loc = 8'h19, t_rem = 8'h20, d;
	int n_fail = 0, checks = 0, cyc = 0, clat = 4, cd = 0, nreq = 0, nloc = 0, n0, g;
	wire logic sda_line = hsda & ~sda_oe;
	tsac_host_model h (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(hsda));
	tsac_top #(.SLAVE_ADDR(SA), .AUTO_PERIOD_CYC(AP), .REMOTE_PERIOD_CYC(RP)) dut (.clk(clk),
		.nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .conv_req(conv_req), .conv_sel(conv_sel),
		.conv_done(conv_done), .conv_data(conv_sel ? {t_rem, 2'h0} : {t_loc, 2'h0}),
		.diode_fault(diode_fault));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			report_and_stop;
		end
	end
	// converter: one done pulse clat cycles after each request
	always @(negedge clk) begin
		conv_done <= 1'b0;
		if (conv_req) begin
			cd <= clat;
			nreq++;
			if (!conv_sel) nloc++;
		end else if (cd > 0) begin
			cd <= cd - 1;
			conv_done <= (cd == 1);
		end
	end
	////////////////////////////////////////
	task automatic report_and_stop;
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	task automatic al(input logic e, input string m);
		chk({7'h0, alert_oe}, {7'h0, e}, m);
	endtask : al
	task automatic wr(input logic [7:0] p, input logic [7:0] v, input logic two);
		h.start();
		h.wbyte({SA, 1'b0}, ack);
		chk({7'h0, ack}, 8'h00, "address ack");
		h.wbyte(p, ack);
		if (two) h.wbyte(v, ack);
		h.stop();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] comp, output logic [7:0] v);
		h.start();
		h.wbyte({a, 1'b1}, ack);
		h.rbyte(v, comp);
		h.stop();
	endtask : rd
	task automatic rr(input logic [7:0] p, output logic [7:0] v);
		wr(p, 8'h00, 1'b0);
		rd(SA, 8'hff, v);
	endtask : rr
	task automatic st(output logic [7:0] v);
		rr(tsac_pkg::PTR_STATUS, v);
	endtask : st
	task automatic shot;
		wr(tsac_pkg::PTR_SINGLE_SHOT, 8'h00, 1'b0);
		repeat (40) @(negedge clk);
	endtask : shot
	task automatic gap(input logic s, output int gv);
		int t0;
		t0 = -1;
		gv = 0;
		for (int i = 0; i < 3 * AP && gv == 0; i++) begin
			@(negedge clk);
			if (conv_req && conv_sel === s) begin
				if (t0 >= 0) gv = cyc - t0;
				t0 = cyc;
			end
		end
	endtask : gap
	////////////////////////////////////////
	task automatic t_defaults;
		rd(SA, 8'hff, d);
		chk(d, 8'h19, "receive after reset");
		rr(tsac_pkg::PTR_SETUP_RD, d);
		chk(d, 8'h10, "setup reset");
		wr(tsac_pkg::PTR_LOCAL_LIM_RD, 8'h11, 1'b1);
		rr(tsac_pkg::PTR_LOCAL_LIM_RD, d);
		chk(d, 8'h46, "local limit");
		rr(tsac_pkg::PTR_REMOTE_LIM_RD, d);
		chk(d, 8'h78, "remote limit");
		wr(tsac_pkg::PTR_LOCAL_LIM_WR, 8'h50, 1'b1);
		wr(tsac_pkg::PTR_REMOTE_LIM_WR, 8'h7a, 1'b1);
		rr(tsac_pkg::PTR_LOCAL_LIM_RD, d);
		chk(d, 8'h50, "local limit written");
		rr(tsac_pkg::PTR_REMOTE_LIM_RD, d);
		chk(d, 8'h7a, "remote limit written");
		st(d);
		chk(d & 8'h7f, 8'h00, "status reset");
		al(1'b0, "alert reset");
		rd(7'h49, 8'hff, d);
		chk({7'h0, ack}, 8'h01, "foreign address");
	endtask : t_defaults
	task automatic t_rates;
		gap(1'b0, g);
		chk({7'h0, g > AP - 3 && g < AP + 3}, 8'h01, "auto period");
		repeat (200) @(negedge clk);
		n0 = nreq;
		shot;
		chk(8'(nreq - n0), 8'h00, "shot ignored when running");
		wr(tsac_pkg::PTR_SETUP_WR, 8'h30, 1'b1);
		n0 = nloc;
		gap(1'b1, g);
		chk({7'h0, g > RP - 3 && g < RP + 3}, 8'h01, "remote period");
		chk(8'(nloc - n0), 8'h00, "local skipped");
	endtask : t_rates
	task automatic t_single;
		wr(tsac_pkg::PTR_SETUP_WR, 8'h50, 1'b1);
		clat = 1500;
		repeat (3000) @(negedge clk);
		n0 = nreq;
		repeat (4000) @(negedge clk);
		chk(8'(nreq - n0), 8'h00, "standby idle");
		shot;
		st(d);
		chk({7'h0, d[7]}, 8'h01, "busy shown");
		shot;
		repeat (4000) @(negedge clk);
		chk(8'(nreq - n0), 8'h02, "one sequence");
		st(d);
		chk({7'h0, d[7]}, 8'h00, "busy gone");
		clat = 4;
	endtask : t_single
	task automatic t_alert;
		t_loc = 8'h50;
		t_rem = 8'h7a;
		shot;
		al(1'b0, "single fault");
		shot;
		al(1'b1, "two faults");
		st(d);
		chk(d, 8'h50, "hot flags");
		al(1'b1, "latch kept");
		rd(tsac_pkg::ALERT_RESP_ADDR, 8'h20, d);
		chk(d, 8'h20, "rival wins");
		al(1'b1, "loser holds alert");
		rd(tsac_pkg::ALERT_RESP_ADDR, 8'hff, d);
		chk(d, {SA, 1'b0}, "alert reply");
		al(1'b0, "reply clears");
		rd(tsac_pkg::ALERT_RESP_ADDR, 8'hff, d);
		chk({7'h0, ack}, 8'h01, "no reply when clear");
		shot;
		al(1'b1, "reassert");
		wr(tsac_pkg::PTR_SETUP_WR, 8'hd0, 1'b1);
		al(1'b0, "masked");
		wr(tsac_pkg::PTR_SETUP_WR, 8'h50, 1'b1);
		al(1'b1, "unmasked");
		t_loc = 8'h10;
		t_rem = 8'h10;
		shot;
		st(d);
		chk(d, 8'h50, "flags before clear");
		al(1'b0, "status read clears");
		st(d);
		chk(d, 8'h00, "flags cleared");
		wr(tsac_pkg::PTR_SETUP_WR, 8'h40, 1'b1);
		t_loc = 8'h50;
		shot;
		al(1'b1, "single fault alerts");
		t_loc = 8'h10;
		shot;
		st(d);
		chk(d, 8'h40, "local flag only");
	endtask : t_alert
	task automatic t_diode;
		diode_fault = 1'b1;
		shot;
		rr(tsac_pkg::PTR_REMOTE_TEMP, d);
		chk(d, 8'hff, "fault result");
		al(1'b0, "no diode alert");
		st(d);
		chk(d, 8'h04, "open set");
		st(d);
		chk(d, 8'h04, "open held");
		diode_fault = 1'b0;
		st(d);
		chk(d, 8'h04, "open last");
		st(d);
		chk(d, 8'h00, "open cleared");
	endtask : t_diode
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		t_defaults;
		t_rates;
		t_single;
		t_alert;
		t_diode;
		report_and_stop;
	end
endmodule : tsac_top_tb_top
`default_nettype wire
